// ==== logic/audio_pb_pkg.sv ====
// shared constants, types and decoders of the audio playback control block
package audio_pb_pkg;

  // clock and rate generation
  localparam int CLK_PERIOD_NS = 5;
  localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int RATE_TICK_HZ = 8_000_000;
  localparam int RATE_PRESCALE = CLK_HZ / RATE_TICK_HZ;
  localparam int RATE_W = 11;

  // apb geometry: printed offsets are word indices, byte address is four times that
  localparam int APB_AW = 18;
  localparam int APB_DW = 32;
  localparam logic [15:0] IDX_FIFO_DATA = 16'hf2b0;
  localparam logic [15:0] IDX_FIFO_FINAL = 16'hf2b1;
  localparam logic [15:0] IDX_STOP_LEN = 16'hf2b2;
  localparam logic [15:0] IDX_STATUS = 16'hf2b3;
  localparam logic [15:0] IDX_MODE = 16'hf2b4;
  localparam logic [15:0] IDX_TYPE = 16'hf2b5;
  localparam logic [15:0] IDX_VOL = 16'hf2b6;
  localparam logic [15:0] IDX_CTRL = 16'hf2b7;
  localparam logic [15:0] IDX_VOL_STAT = 16'hf2c0;

  // field positions
  localparam int MODE_VOLPS_BIT = 7;
  localparam int MODE_THR_LSB = 0;
  localparam int TYPE_ALG_LSB = 4;
  localparam int TYPE_RATE_LSB = 0;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_HALT_BIT = 4;
  localparam int STOP_LEN_LSB = 3;
  localparam int STAT_ERR_BIT = 7;
  localparam int STAT_PWRDN_BIT = 4;
  localparam int STAT_DEND_BIT = 3;
  localparam int STAT_FULL_BIT = 2;
  localparam int STAT_ABOVE_BIT = 1;
  localparam int STAT_EMPTY_BIT = 0;

  // reset values
  localparam logic [7:0] TYPE_RST = 8'h41;
  localparam logic [4:0] VOL_RST = 5'h09;

  // fifo sizing and start levels
  localparam int FIFO_DEPTH_DEF = 32;
  localparam logic [5:0] START_LVL = 6'h04;
  localparam logic [5:0] START_LVL_HQ = 6'h0c;
  localparam logic [2:0] HQ_PHASES = 3'h4;

  // algorithm codes
  localparam logic [2:0] ALG_ADPCM4 = 3'h1;
  localparam logic [2:0] ALG_NLPCM8 = 3'h2;
  localparam logic [2:0] ALG_PCM8 = 3'h3;
  localparam logic [2:0] ALG_PCM16 = 3'h4;
  localparam logic [2:0] ALG_HQ = 3'h5;

  typedef enum logic [1:0] {PB_OFF, PB_WAIT, PB_PLAY} pb_state_t;

  typedef enum logic [3:0] {
    RID_FIFO_DATA, RID_FIFO_FINAL, RID_STOP_LEN, RID_STATUS, RID_MODE,
    RID_TYPE, RID_VOL, RID_CTRL, RID_VOL_STAT, RID_NONE
  } reg_id_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [APB_DW-1:0] prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic sample_valid;
    logic [15:0] sample;
    logic [4:0] volume;
  } audio_out_t;

  function automatic logic [APB_AW-1:0] byte_addr(input logic [15:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr

  // request level in bytes for each threshold code
  function automatic logic [5:0] thr_level(input logic [2:0] code);
    case (code)
      3'h0: thr_level = 6'h01;
      3'h1: thr_level = 6'h0a;
      3'h2: thr_level = 6'h04;
      3'h3: thr_level = 6'h08;
      3'h4: thr_level = 6'h0c;
      3'h5: thr_level = 6'h10;
      3'h6: thr_level = 6'h14;
      default: thr_level = 6'h18;
    endcase
  endfunction : thr_level

  // sample period in rate ticks, zero for a prohibited code
  function automatic logic [RATE_W-1:0] rate_period(input logic [3:0] code);
    case (code)
      4'h1: rate_period = RATE_W'(RATE_TICK_HZ / 8000);
      4'h2: rate_period = RATE_W'(RATE_TICK_HZ / 16000);
      4'h3: rate_period = RATE_W'(RATE_TICK_HZ / 32000);
      4'h5: rate_period = RATE_W'(RATE_TICK_HZ * 3 / 32000);
      4'h6: rate_period = RATE_W'(RATE_TICK_HZ * 3 / 64000);
      4'h8: rate_period = RATE_W'(RATE_TICK_HZ / 6400);
      4'h9: rate_period = RATE_W'(RATE_TICK_HZ / 12800);
      4'ha: rate_period = RATE_W'(RATE_TICK_HZ / 25600);
      default: rate_period = '0;
    endcase
  endfunction : rate_period

  function automatic logic alg_legal(input logic [2:0] code);
    alg_legal = (code >= ALG_ADPCM4) && (code <= ALG_HQ);
  endfunction : alg_legal

endpackage : audio_pb_pkg

// ==== logic/sample_rate_divider.sv ====
// sample-rate tick generator: prescaler to a rate tick, then a per-code period
module sample_rate_divider import audio_pb_pkg::*; #(
  parameter int PRESCALE = RATE_PRESCALE
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [3:0] rate_code,
  output logic tick
);

  if (PRESCALE < 1 || PRESCALE > 255) begin : g_bad_prescale
    $error("sample_rate_divider: PRESCALE out of range");
  end

  typedef struct packed {
    logic [7:0] pre;
    logic [RATE_W-1:0] cnt;
    logic tick;
  } div_t;

  div_t q;
  div_t n;

  // counters idle while disabled so every phrase starts a full period
  always_comb begin
    n = q;
    n.tick = 1'b0;
    if (!enable || rate_period(rate_code) == '0) begin
      n.pre = '0;
      n.cnt = '0;
    end else if (q.pre == 8'(PRESCALE - 1)) begin
      n.pre = '0;
      if (q.cnt == rate_period(rate_code) - RATE_W'(1)) begin
        n.cnt = '0;
        n.tick = 1'b1;
      end else begin
        n.cnt = q.cnt + RATE_W'(1);
      end
    end else begin
      n.pre = q.pre + 8'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign tick = q.tick;

endmodule : sample_rate_divider

// ==== logic/audio_playback_control.sv ====
// audio playback control: apb registers, audio byte fifo and playback sequencing
// Operation
// - threshold codes map to request levels
// - above-threshold flag clears below level
// - volume apply bit picks apply timing
// - phrase-sync volume waits for next phrase
// - hq mode uses variable bytes per step
// - rate field codes, others not written
// - algorithm field codes, three prohibited
// - type register resets to 41h
// - five-bit volume, 09h is 0 dB
// - run bit starts and stops playback
// - halt stops, zeroes result, empties fifo
// - stop length field in bits 7..3
// - immediate mode: status equals setting
// - phrase mode: status shows volume in use
// - read error on short 16-bit/hq data
// - start once fifo holds start level
// - request irq when count drops below level
module audio_playback_control import audio_pb_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter int PRESCALE = RATE_PRESCALE
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire apb_req_t apb_req,
  output apb_rsp_t apb_rsp,
  output audio_out_t audio_out,
  output logic audio_request_irq
);
  localparam int PW = $clog2(FIFO_DEPTH);
  localparam int CW = PW + 1;
  if (FIFO_DEPTH < 16 || FIFO_DEPTH > 32 || (1 << PW) != FIFO_DEPTH) begin : g_bad_depth
    $error("audio_playback_control: FIFO_DEPTH must be 16 or 32");
  end
  typedef struct packed {
    pb_state_t st;
    logic [FIFO_DEPTH-1:0][8:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [CW-1:0] fin_cnt;
    logic [4:0] stop_len;
    logic vol_at_phrase;
    logic [2:0] thr_sel;
    logic [2:0] alg_sel;
    logic [3:0] rate_sel;
    logic [2:0] alg_play;
    logic [3:0] rate_play;
    logic [4:0] vol_set;
    logic [4:0] vol_applied;
    logic run;
    logic [2:0] phase;
    logic err;
    logic dend;
    logic above;
    logic [15:0] sample;
    logic sample_vld;
    logic irq;
    logic [APB_DW-1:0] rdata;
  } st_t;
  st_t q;
  st_t n;
  logic tick;
  ////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read, write and error answer
  function automatic reg_id_t reg_sel(input logic [APB_AW-1:0] a);
    if (a == byte_addr(IDX_FIFO_DATA)) reg_sel = RID_FIFO_DATA;
    else if (a == byte_addr(IDX_FIFO_FINAL)) reg_sel = RID_FIFO_FINAL;
    else if (a == byte_addr(IDX_STOP_LEN)) reg_sel = RID_STOP_LEN;
    else if (a == byte_addr(IDX_STATUS)) reg_sel = RID_STATUS;
    else if (a == byte_addr(IDX_MODE)) reg_sel = RID_MODE;
    else if (a == byte_addr(IDX_TYPE)) reg_sel = RID_TYPE;
    else if (a == byte_addr(IDX_VOL)) reg_sel = RID_VOL;
    else if (a == byte_addr(IDX_CTRL)) reg_sel = RID_CTRL;
    else if (a == byte_addr(IDX_VOL_STAT)) reg_sel = RID_VOL_STAT;
    else reg_sel = RID_NONE;
  endfunction : reg_sel
  // bytes needed by the running algorithm at this step
  function automatic logic [1:0] step_need(input logic [2:0] alg, input logic [2:0] ph);
    case (alg)
      ALG_ADPCM4: step_need = ph[0] ? 2'd1 : 2'd0;
      ALG_PCM16: step_need = 2'd2;
      ALG_HQ: step_need = (ph == HQ_PHASES) ? 2'd2 : 2'd0;
      default: step_need = 2'd1;
    endcase
  endfunction : step_need
  sample_rate_divider #(
    .PRESCALE(PRESCALE)
  ) u_rate (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .enable(q.st == PB_PLAY),
    .rate_code(q.rate_play),
    .tick(tick)
  );
  ////////////////////////////////////////////////////////////////////////////
  // next-state logic: synthesis step, register access, fifo push
  always_comb begin
    logic acc_wr;
    logic [8:0] b0;
    logic [8:0] b1;
    logic [1:0] need;
    logic fin_pop;
    logic push;
    logic push_fin;
    reg_id_t rid;
    logic [1:0] flag_set;
    acc_wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
    rid = reg_sel(apb_req.paddr);
    b0 = q.mem[q.rp];
    b1 = q.mem[q.rp + PW'(1)];
    need = step_need(q.alg_play, q.phase);
    fin_pop = 1'b0;
    push = 1'b0;
    push_fin = 1'b0;
    flag_set = 2'b00; // error and data-end sets outrank a same-cycle clear
    n = q;
    n.sample_vld = 1'b0;
    n.irq = 1'b0;

    // one synthesis step per sample tick; hq takes two bytes every fifth step
    if (q.st == PB_PLAY && tick) begin
      if ((q.alg_play == ALG_PCM16 && q.cnt == CW'(1)) ||
          (q.alg_play == ALG_HQ && q.cnt >= CW'(1) && q.cnt <= CW'(3) &&
           q.fin_cnt == '0)) begin
        n.err = 1'b1;
        flag_set[0] = 1'b1;
      end
      if (q.alg_play == ALG_HQ) begin
        n.phase = (q.phase == HQ_PHASES) ? 3'h0 : q.phase + 3'h1;
      end else begin
        n.phase = {2'b00, ~q.phase[0]};
      end
      if (q.cnt >= CW'(need)) begin
        n.sample_vld = 1'b1;
        case (q.alg_play)
          ALG_ADPCM4: n.sample = {q.phase[0] ? b0[3:0] : b0[7:4], 12'h000};
          ALG_PCM16: n.sample = {b1[7:0], b0[7:0]};
          ALG_HQ: n.sample = q.sample;
          default: n.sample = {b0[7:0], 8'h00};
        endcase
        fin_pop = (need != 2'd0 && b0[8]) || (need == 2'd2 && b1[8]);
        n.rp = q.rp + PW'(need);
        n.cnt = q.cnt - CW'(need);
        n.fin_cnt = q.fin_cnt - CW'(fin_pop);
        if (fin_pop) begin
          n.st = PB_WAIT;
          n.phase = '0;
          n.dend = (n.cnt == '0);
          flag_set[1] = (n.cnt == '0);
        end
      end
    end

    if (q.st == PB_WAIT && q.run &&
        q.cnt >= ((q.alg_sel == ALG_HQ) ? CW'(START_LVL_HQ) : CW'(START_LVL))) begin
      n.st = PB_PLAY;
      n.alg_play = q.alg_sel;
      n.rate_play = q.rate_sel;
      n.phase = '0;
      if (q.vol_at_phrase) begin
        n.vol_applied = q.vol_set;
      end
    end

    // register writes take effect at the access edge
    if (acc_wr) begin
      unique case (rid)
        RID_FIFO_DATA: push = 1'b1;
        RID_FIFO_FINAL: begin
          push = 1'b1;
          push_fin = 1'b1;
        end
        RID_STOP_LEN: n.stop_len = apb_req.pwdata[STOP_LEN_LSB +: 5];
        RID_MODE: begin
          n.vol_at_phrase = apb_req.pwdata[MODE_VOLPS_BIT];
          n.thr_sel = apb_req.pwdata[MODE_THR_LSB +: 3];
        end
        RID_TYPE: begin
          if (alg_legal(apb_req.pwdata[TYPE_ALG_LSB +: 3])) begin
            n.alg_sel = apb_req.pwdata[TYPE_ALG_LSB +: 3];
          end
          if (rate_period(apb_req.pwdata[TYPE_RATE_LSB +: 4]) != '0) begin
            n.rate_sel = apb_req.pwdata[TYPE_RATE_LSB +: 4];
          end
        end
        RID_VOL: n.vol_set = apb_req.pwdata[4:0];
        RID_CTRL: begin
          n.run = apb_req.pwdata[CTRL_RUN_BIT];
          if (!n.run) begin
            n.st = PB_OFF;
            n.err = flag_set[0];
            n.dend = flag_set[1];
          end else if (q.st == PB_OFF) begin
            n.st = PB_WAIT;
          end
          if (apb_req.pwdata[CTRL_HALT_BIT]) begin
            n.st = n.run ? PB_WAIT : PB_OFF;
            n.wp = '0;
            n.rp = '0;
            n.cnt = '0;
            n.fin_cnt = '0;
            n.sample = 16'h0000;
            n.phase = '0;
            n.err = flag_set[0];
          end
        end
        default: ;
      endcase
    end

    // bytes beyond a full fifo are dropped; an accepted fifo byte ends the data-end state unless a data end is set in that cycle
    if (push && n.cnt < CW'(FIFO_DEPTH)) begin
      n.mem[n.wp] = {push_fin, apb_req.pwdata[7:0]};
      n.wp = n.wp + PW'(1);
      n.cnt = n.cnt + CW'(1);
      n.fin_cnt = n.fin_cnt + CW'(push_fin);
      n.dend = flag_set[1];
    end

    if (!n.vol_at_phrase) begin
      n.vol_applied = n.vol_set;
    end

    n.above = (n.cnt >= CW'(thr_level(n.thr_sel)));
    n.irq = (q.above && !n.above) || (n.dend && !q.dend) || (n.err && !q.err);
    // read data captured in the setup phase so the access phase needs no wait
    n.rdata = '0;
    if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
      unique case (rid)
        RID_STOP_LEN: n.rdata[7:0] = {q.stop_len, 3'b000};
        RID_MODE: begin
          n.rdata[MODE_VOLPS_BIT] = q.vol_at_phrase;
          n.rdata[MODE_THR_LSB +: 3] = q.thr_sel;
        end
        RID_TYPE: begin
          n.rdata[TYPE_ALG_LSB +: 3] = q.alg_sel;
          n.rdata[TYPE_RATE_LSB +: 4] = q.rate_sel;
        end
        RID_VOL: n.rdata[4:0] = q.vol_set;
        RID_CTRL: n.rdata[CTRL_RUN_BIT] = q.run;
        RID_STATUS: begin
          n.rdata[STAT_ERR_BIT] = q.err;
          n.rdata[STAT_PWRDN_BIT] = (q.st == PB_OFF);
          n.rdata[STAT_DEND_BIT] = q.dend;
          n.rdata[STAT_FULL_BIT] = (q.cnt == CW'(FIFO_DEPTH));
          n.rdata[STAT_ABOVE_BIT] = q.above;
          n.rdata[STAT_EMPTY_BIT] = (q.cnt == '0);
        end
        RID_VOL_STAT: n.rdata[4:0] = q.vol_applied;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // state register; type reset value
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      q <= '0;
      q.alg_sel <= TYPE_RST[TYPE_ALG_LSB +: 3];
      q.rate_sel <= TYPE_RST[TYPE_RATE_LSB +: 4];
      q.alg_play <= TYPE_RST[TYPE_ALG_LSB +: 3];
      q.rate_play <= TYPE_RST[TYPE_RATE_LSB +: 4];
      q.vol_set <= VOL_RST;
      q.vol_applied <= VOL_RST;
    end else begin
      q <= n;
    end
  end
  // zero-wait apb answer; unmapped addresses answer with an error
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel && apb_req.penable &&
                           (reg_sel(apb_req.paddr) == RID_NONE);
  assign apb_rsp.prdata = q.rdata;
  assign audio_out.sample_valid = q.sample_vld;
  assign audio_out.sample = q.sample;
  assign audio_out.volume = q.vol_applied;
  assign audio_request_irq = q.irq;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic wr_ctrl;
  assign wr_ctrl = apb_req.psel && apb_req.penable && apb_req.pwrite &&
                   reg_sel(apb_req.paddr) == RID_CTRL;
  thr_flag_a: assert property (q.above == (q.cnt >= CW'(thr_level(q.thr_sel))))
    else $error("above-threshold flag disagrees with fifo count");
  vol_mirror_a: assert property (!q.vol_at_phrase |-> q.vol_applied == q.vol_set)
    else $error("applied volume differs from setting in immediate mode");
  vol_hold_a: assert property ((q.st == PB_PLAY && q.vol_at_phrase) ##1
      (q.st == PB_PLAY && q.vol_at_phrase) |-> $stable(q.vol_applied))
    else $error("volume changed mid-phrase in phrase mode");
  halt_clear_a: assert property (wr_ctrl && apb_req.pwdata[CTRL_HALT_BIT] |=>
      q.cnt == '0 && q.sample == 16'h0000 && q.st != PB_PLAY)
    else $error("halt did not empty fifo and zero the result");
  start_gate_a: assert property ((q.st == PB_WAIT) ##1 (q.st == PB_PLAY) |->
      $past(q.cnt) >= ((q.alg_play == ALG_HQ) ? CW'(START_LVL_HQ) : CW'(START_LVL)))
    else $error("playback started below start level");
  err_short_a: assert property (q.st == PB_PLAY && tick && q.alg_play == ALG_PCM16 &&
      q.cnt == CW'(1) && !wr_ctrl |=> q.err)
    else $error("short 16-bit read not flagged");
  irq_fall_a: assert property ($fell(q.above) |-> audio_request_irq)
    else $error("no request irq when count fell below level");
  type_reset_a: assert property (!$past(nrst) |-> q.alg_sel == ALG_PCM16 &&
      q.rate_sel == 4'h1 && q.vol_set == VOL_RST)
    else $error("type or volume reset value wrong");
  run_bit_a: assert property (wr_ctrl |=> q.run == $past(apb_req.pwdata[CTRL_RUN_BIT]))
    else $error("run bit did not follow write");
  rd_upper_a: assert property (q.rdata[APB_DW-1:8] == '0)
    else $error("upper read data not zero");
  play_start_c: cover property ((q.st == PB_WAIT) ##1 (q.st == PB_PLAY));
  phrase_end_c: cover property ($rose(q.dend));
  halt_c: cover property (wr_ctrl && apb_req.pwdata[CTRL_HALT_BIT] && q.st == PB_PLAY);
  read_err_c: cover property ($rose(q.err));
endmodule : audio_playback_control

// ==== verification/amp_model.sv ====
// speaker amplifier stand-in fed by the playback result and applied volume
module amp_model import audio_pb_pkg::*; (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire audio_out_t audio_out,
  output logic [15:0] level_q,
  output logic [4:0] gain,
  output logic muted,
  output int samples
);
  timeunit 1ns;
  timeprecision 1ps;

  assign gain = audio_out.volume;
  assign muted = (audio_out.volume == 5'h1f);

  // zeroed result reaches the filter
  // the filter sees the held result every cycle; steps are only counted
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      level_q <= 16'h0000;
      samples <= 0;
    end else begin
      level_q <= audio_out.sample;
      if (audio_out.sample_valid) begin
        samples <= samples + 1;
      end
    end
  end
endmodule : amp_model

// ==== verification/audio_playback_control_tb.sv ====
// self-checking bench: apb register and playback sequences
module audio_playback_control_tb import audio_pb_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk;
  logic nrst;
  apb_req_t apb_req;
  apb_rsp_t apb_rsp;
  audio_out_t audio_out;
  logic audio_request_irq;
  logic [15:0] level;
  logic [4:0] gain;
  logic muted;
  int samples;
  int num_errors = 0;
  int samples_checked = 0;
  int irq_cnt;
  int n0;
  logic [7:0] d;
  logic e;
  logic [3:0] rates [8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
  logic [7:0] bad [8] = '{8'h00, 8'h64, 8'h77, 8'h0b, 8'h6c, 8'h7d, 8'h6e, 8'h0f};
  int lvls [8] = '{1, 10, 4, 8, 12, 16, 20, 24};
  logic [7:0] pcm [5] = '{8'hef, 8'hbe, 8'h34, 8'h12, 8'haa};

  // prescale 1 keeps an 8 khz period at 1000 clocks
  audio_playback_control #(.FIFO_DEPTH(32), .PRESCALE(1)) uut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .apb_req(apb_req),
    .apb_rsp(apb_rsp),
    .audio_out(audio_out),
    .audio_request_irq(audio_request_irq)
  );
  amp_model amp (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .audio_out(audio_out),
    .level_q(level),
    .gain(gain),
    .muted(muted),
    .samples(samples)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // interrupt pulses counted
  always @(posedge ref_clk) begin
    if (!nrst) irq_cnt <= 0;
    else if (audio_request_irq === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    samples_checked++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      num_errors++;
    end
  endtask : chk

  // one apb transfer; outputs are read at the edge, before its updates land
  task automatic xfer(input logic w, input logic [15:0] i, input logic [7:0] v);
    int n;
    @(posedge ref_clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= w;
    apb_req.paddr <= {i, 2'b00};
    apb_req.pwdata <= {24'h000000, v};
    @(posedge ref_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    d = apb_rsp.prdata[7:0];
    e = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    if (n >= 50) chk("pready", 16'h1, 16'h0);
  endtask : xfer

  task automatic wr(input logic [15:0] i, input logic [7:0] v);
    xfer(1'b1, i, v);
  endtask : wr

  task automatic rd(input logic [15:0] i, input logic [7:0] x, input string n);
    xfer(1'b0, i, 8'h00);
    chk(n, {8'h00, x}, {8'h00, d});
    chk({n, "_err"}, 16'h0, {15'h0, e});
  endtask : rd

  task automatic stbit(input int b, input logic x, input string n);
    xfer(1'b0, IDX_STATUS, 8'h00);
    chk(n, {15'h0, x}, {15'h0, d[b]});
  endtask : stbit

  task automatic wait_smp(input logic [15:0] x);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (audio_out.sample_valid !== 1'b1 && n < 2000);
    chk("sample_valid", 16'h1, {15'h0, audio_out.sample_valid});
    chk("sample", x, audio_out.sample);
  endtask : wait_smp

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  //////////////////////////////////////////////////////////////////////
  initial begin
    apb_req = '0;
    nrst = 1'b0;
    repeat (8) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(IDX_STOP_LEN, 8'h00, "stop_len");
    rd(IDX_MODE, 8'h00, "mode");
    rd(IDX_TYPE, 8'h41, "type");
    rd(IDX_VOL, 8'h09, "volume");
    rd(IDX_CTRL, 8'h00, "control");
    rd(IDX_STATUS, 8'h11, "status");
    rd(IDX_VOL_STAT, 8'h09, "vol_status");
    xfer(1'b0, 16'hf2bf, 8'h00);
    chk("unmapped_err", 16'h1, {15'h0, e});
    $display("test reset values done");
    wr(IDX_STOP_LEN, 8'hff);
    rd(IDX_STOP_LEN, 8'hf8, "stop_len_w");
    wr(IDX_MODE, 8'hff);
    rd(IDX_MODE, 8'h87, "mode_w");
    wr(IDX_MODE, 8'h00);
    wr(IDX_VOL, 8'hff);
    rd(IDX_VOL, 8'h1f, "vol_w");
    wr(IDX_VOL_STAT, 8'h00);
    rd(IDX_VOL_STAT, 8'h1f, "vol_stat_imm");
    chk("amp_muted", 16'h1, {15'h0, muted});
    wr(IDX_CTRL, 8'h01);
    rd(IDX_CTRL, 8'h01, "run_set");
    wr(IDX_CTRL, 8'h00);
    rd(IDX_CTRL, 8'h00, "run_clr");
    $display("test register fields done");
    // every legal code, then prohibited ones
    for (int i = 0; i < 8; i++) begin
      wr(IDX_TYPE, {1'b1, 3'(i % 5 + 1), rates[i]});
      rd(IDX_TYPE, {1'b0, 3'(i % 5 + 1), rates[i]}, "type_ok");
    end
    for (int i = 0; i < 8; i++) begin
      wr(IDX_TYPE, bad[i]);
      rd(IDX_TYPE, 8'h3a, "type_bad");
    end
    wr(IDX_TYPE, 8'h1f);
    rd(IDX_TYPE, 8'h1a, "type_part");
    $display("test type codes done");
    // each request level, one below and at the level
    for (int c = 0; c < 8; c++) begin
      wr(IDX_CTRL, 8'h10);
      rd(IDX_STATUS, 8'h11, "halt_status");
      wr(IDX_MODE, 8'(c));
      for (int k = 1; k < lvls[c]; k++) wr(IDX_FIFO_DATA, 8'(k));
      stbit(1, 1'b0, "below_level");
      wr(IDX_FIFO_DATA, 8'h5a);
      stbit(1, 1'b1, "at_level");
    end
    $display("test thresholds done");
    // 16-bit play, short read, halt and resume
    wr(IDX_CTRL, 8'h10);
    wr(IDX_MODE, 8'h00);
    wr(IDX_TYPE, 8'h43);
    wr(IDX_CTRL, 8'h01);
    foreach (pcm[j]) wr(IDX_FIFO_DATA, pcm[j]);
    wait_smp(16'hbeef);
    wait_smp(16'h1234);
    repeat (300) @(posedge ref_clk);
    stbit(7, 1'b1, "read_error");
    wr(IDX_CTRL, 8'h11);
    rd(IDX_STATUS, 8'h01, "halt_run_status");
    chk("sample_zero", 16'h0, audio_out.sample);
    chk("amp_level", 16'h0, level);
    n0 = samples;
    for (int k = 1; k < 4; k++) wr(IDX_FIFO_DATA, 8'(k));
    repeat (600) @(posedge ref_clk);
    chk("no_start", 16'(n0), 16'(samples));
    wr(IDX_FIFO_DATA, 8'h04);
    wait_smp(16'h0201);
    $display("test pcm16 halt done");
    // nibble decoder takes the high nibble first, then the byte decoder
    wr(IDX_CTRL, 8'h10);
    wr(IDX_TYPE, 8'h13);
    wr(IDX_CTRL, 8'h01);
    foreach (pcm[j]) wr(IDX_FIFO_DATA, pcm[j]);
    wait_smp(16'he000);
    wait_smp(16'hf000);
    wait_smp(16'hb000);
    wr(IDX_CTRL, 8'h10);
    wr(IDX_TYPE, 8'h23);
    wr(IDX_CTRL, 8'h01);
    foreach (pcm[j]) wr(IDX_FIFO_DATA, pcm[j]);
    wait_smp(16'hef00);
    $display("test nibble and byte decoders done");
    // phrase-synchronous volume; period 250 clocks at 32 khz
    wr(IDX_CTRL, 8'h10);
    wr(IDX_MODE, 8'h80);
    wr(IDX_VOL, 8'h05);
    wr(IDX_TYPE, 8'h33);
    wr(IDX_CTRL, 8'h01);
    for (int k = 0; k < 3; k++) wr(IDX_FIFO_DATA, 8'(k));
    wr(IDX_FIFO_FINAL, 8'h44);
    repeat (300) @(posedge ref_clk);
    wr(IDX_VOL, 8'h10);
    rd(IDX_VOL_STAT, 8'h05, "vol_pending");
    chk("amp_gain", 16'h5, {11'h0, gain});
    repeat (1000) @(posedge ref_clk);
    rd(IDX_VOL_STAT, 8'h05, "vol_between");
    for (int k = 0; k < 4; k++) wr(IDX_FIFO_DATA, 8'(k));
    repeat (20) @(posedge ref_clk);
    rd(IDX_VOL_STAT, 8'h10, "vol_applied");
    wr(IDX_MODE, 8'h00);
    wr(IDX_VOL, 8'h07);
    rd(IDX_VOL_STAT, 8'h07, "vol_immediate");
    $display("test volume timing done");
    // hq start level and drain interrupt
    wr(IDX_CTRL, 8'h10);
    wr(IDX_MODE, 8'h01);
    wr(IDX_TYPE, 8'h53);
    wr(IDX_CTRL, 8'h01);
    wr(IDX_STOP_LEN, 8'h28);
    rd(IDX_STOP_LEN, 8'h28, "hq_stop_len");
    wr(IDX_FIFO_DATA, 8'h28);
    for (int k = 1; k < 11; k++) wr(IDX_FIFO_DATA, 8'(k));
    repeat (3000) @(posedge ref_clk);
    stbit(1, 1'b1, "hq_not_started");
    n0 = irq_cnt;
    wr(IDX_FIFO_DATA, 8'h0b);
    repeat (3000) @(posedge ref_clk);
    stbit(1, 1'b0, "hq_drained");
    chk("irq_count", 16'h1, 16'(irq_cnt - n0));
    $display("test hq pacing done");
    conclude();
  end

  // hang guard, well past the expected run length
  initial begin
    repeat (40000) @(posedge ref_clk);
    num_errors++;
    conclude();
  end
endmodule : audio_playback_control_tb
